// ==== hdl/arinc_out_pkg.sv ====
// shared constants and types for the word output stage
package arinc_out_pkg;
    localparam int WORD_BITS     = 32;
    localparam int LABEL_BITS    = 8;
    localparam int LABEL_FIRST   = 0;    // index of word bit 1 (label msb)
    localparam int SD_LO_IDX     = 8;    // word bit 9
    localparam int SD_HI_IDX     = 9;    // word bit 10
    localparam int PARITY_IDX    = 31;   // word bit 32
    localparam int CLK_PERIOD_NS = 8;
    localparam int REF_PERIOD_NS = 1000; // one period of the 1 MHz reference
    localparam int REF_CYCLES    = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_CNT_W     = 8;
    localparam logic [REF_CNT_W-1:0] REF_LOAD = REF_CNT_W'(REF_CYCLES - 1);
    localparam int BIT_CNT_W     = 6;
    localparam logic [BIT_CNT_W-1:0] BITS_FULL = BIT_CNT_W'(WORD_BITS);
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [WORD_BITS-1:0] WORD_ONES = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } out_state_e;
endpackage

// ==== hdl/two_entry_buffer.sv ====
// small valid/ready word buffer between acceptance and the output latch
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer
    import arinc_out_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             clear,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
    } buf_s;

    buf_s st_reg;
    buf_s st_next;
    logic push;
    logic pop;

    // honest full and empty straight from the count register
    assign inReady  = (st_reg.count != CNT_FULL);
    assign outValid = (st_reg.count != '0);
    assign outData  = st_reg.mem[st_reg.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wrPtr] = inData;
            st_next.wrPtr = (st_reg.wrPtr == PTR_LAST) ? '0 : st_reg.wrPtr + 1'b1;
        end
        if (pop) begin
            st_next.rdPtr = (st_reg.rdPtr == PTR_LAST) ? '0 : st_reg.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
        if (clear) begin
            st_next = '0;
        end
        if (!ce) begin
            st_next = st_reg;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // two_entry_buffer
`default_nettype wire

// ==== hdl/label_matcher.sv ====
// label and source/destination acceptance test for one received word
`timescale 1ns/100ps
`default_nettype none
module label_matcher
    import arinc_out_pkg::*;
#(
    parameter bit ENHANCED = 1'b1
) (
    input  wire logic [WORD_BITS-1:0]  word,
    input  wire logic [LABEL_BITS-1:0] label_match_primary,
    input  wire logic [LABEL_BITS-1:0] labelMask,
    input  wire logic [LABEL_BITS-1:0] label_match_second,
    input  wire logic [LABEL_BITS-1:0] label_match_third,
    input  wire logic                  secondEnable,
    input  wire logic                  thirdEnable,
    input  wire logic                  sdEnable,
    input  wire logic [1:0]            sdValue,
    output logic                       accept
);
    // word bit 1 is label bit 7, word bit 8 is label bit 0
    function automatic logic [LABEL_BITS-1:0] labelOf(input logic [WORD_BITS-1:0] w);
        logic [LABEL_BITS-1:0] l;
        l = '0;
        for (int i = 0; i < LABEL_BITS; i++) begin
            l[LABEL_BITS-1-i] = w[LABEL_FIRST+i];
        end
        return l;
    endfunction

    logic [LABEL_BITS-1:0] label;
    logic                  hitPrimary;
    logic                  hitSecond;
    logic                  hitThird;
    logic                  sdOk;

    // masked primary match, exact second and third matches
    assign label      = labelOf(word);
    assign hitPrimary = ((label ^ label_match_primary) & labelMask) == '0;
    assign hitSecond  = ENHANCED && secondEnable && (label == label_match_second);
    assign hitThird   = ENHANCED && thirdEnable && (label == label_match_third);
    assign sdOk       = !sdEnable || ({word[SD_HI_IDX], word[SD_LO_IDX]} == sdValue);
    assign accept     = (hitPrimary || hitSecond || hitThird) && sdOk;
endmodule // label_matcher
`default_nettype wire

// ==== hdl/arinc_word_output_stage.sv ====
// word output stage: assembly, parity, filtering, output latch and strobe
`timescale 1ns/100ps
`default_nettype none
// How it works
// - each true output n carries bit n of the last accepted word and changes only when the strobe rises or on a reset.
// - the enhanced variant drives a complement of every true output, updated on the same strobe edge.
// - with parity checking on, the last output shows the parity error flag, otherwise raw bit 32.
// - the enhanced variant shows every received bit, filtered or not, on a serial clock and data pair.
// - the enhanced variant accepts a word when any of three enabled label criteria matches.
// - the base variant keeps all 32 word outputs undriven from reset until the first accepted word.
// - the enhanced variant drives true outputs low and complements high from reset to the first word.
// - the enhanced variant never releases its word outputs.
// - the strobe rises when the latched word reaches the outputs and stays high until a new first bit, a master reset or the next latch load.
// - the active-low master reset clears the output latch and all receiver state.
// - with parity checking on, bit 32 is stored as zero for odd parity and one for even parity.
// - the latch loads one reference period before the strobe rises; a new first bit drops the strobe.
module arinc_word_output_stage
    import arinc_out_pkg::*;
#(
    parameter bit ENHANCED = 1'b1
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire logic                  global_reset_n,
    input  wire logic                  parityEnable,
    input  wire logic                  rxFirstBit,
    input  wire logic                  rxBitStrobe,
    input  wire logic                  rxBitValue,
    input  wire logic                  rxWordDone,
    input  wire logic [LABEL_BITS-1:0] label_match_primary,
    input  wire logic [LABEL_BITS-1:0] labelMask,
    input  wire logic [LABEL_BITS-1:0] label_match_second,
    input  wire logic [LABEL_BITS-1:0] label_match_third,
    input  wire logic                  secondEnable,
    input  wire logic                  thirdEnable,
    input  wire logic                  sdEnable,
    input  wire logic [1:0]            sdValue,
    output logic                       rxReady,
    output logic [WORD_BITS-1:0]       wordOut,
    output logic [WORD_BITS-1:0]       wordOutN,
    output logic [WORD_BITS-1:0]       wordOutEn,
    output logic                       newWordStrobe,
    output logic                       serialClockOut,
    output logic                       serial_word_out
);
    typedef struct packed {
        out_state_e           state;
        logic [REF_CNT_W-1:0] refCount;
        logic [WORD_BITS-1:0] shiftWord;
        logic [BIT_CNT_W-1:0] bitCount;
        logic [WORD_BITS-1:0] acceptWord;
        logic                 acceptValid;
        logic [WORD_BITS-1:0] latchWord;
        logic [WORD_BITS-1:0] trueOut;
        logic [WORD_BITS-1:0] compOut;
        logic [WORD_BITS-1:0] outEnable;
        logic                 strobe;
        logic                 serClock;
        logic                 serData;
    } stage_s;

    // reset image differs by variant: base floats, enhanced drives true outputs low and complements high
    localparam stage_s RESET_STATE = '{
        state:       ST_IDLE,
        refCount:    '0,
        shiftWord:   WORD_ZERO,
        bitCount:    '0,
        acceptWord:  WORD_ZERO,
        acceptValid: 1'b0,
        latchWord:   WORD_ZERO,
        trueOut:     WORD_ZERO,
        compOut:     ENHANCED ? WORD_ONES : WORD_ZERO,
        outEnable:   ENHANCED ? WORD_ONES : WORD_ZERO,
        strobe:      1'b0,
        serClock:    1'b0,
        serData:     1'b0
    };

    stage_s               st_reg;
    stage_s               st_next;
    logic [WORD_BITS-1:0] fullWord;
    logic [WORD_BITS-1:0] checkedWord;
    logic                 wordOk;
    logic                 accept;
    logic                 bufInReady;
    logic                 bufOutValid;
    logic [WORD_BITS-1:0] bufOutData;
    logic                 bufOutReady;
    logic                 masterClear;

    assign masterClear = !global_reset_n;

    // the word being completed includes the bit that arrives with done
    assign fullWord = rxBitStrobe ? {rxBitValue, st_reg.shiftWord[WORD_BITS-1:1]}
                                  : st_reg.shiftWord;
    assign wordOk   = rxWordDone &&
                      ((rxBitStrobe ? st_reg.bitCount + 1'b1 : st_reg.bitCount) == BITS_FULL);

    // parity flag replaces bit 32: zero when odd, one when even
    always_comb begin
        checkedWord = fullWord;
        if (parityEnable) begin
            checkedWord[PARITY_IDX] = ~(^fullWord);
        end
    end

    label_matcher #(
        .ENHANCED            (ENHANCED)
    ) u_match (
        .word                (checkedWord),
        .label_match_primary (label_match_primary),
        .labelMask           (labelMask),
        .label_match_second  (label_match_second),
        .label_match_third   (label_match_third),
        .secondEnable        (secondEnable),
        .thirdEnable         (thirdEnable),
        .sdEnable            (sdEnable),
        .sdValue             (sdValue),
        .accept              (accept)
    );

    assign bufOutReady = (st_reg.state == ST_IDLE);

    two_entry_buffer #(
        .WIDTH    (WORD_BITS),
        .DEPTH    (2)
    ) u_buf (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .clear    (masterClear),
        .inValid  (st_reg.acceptValid),
        .inData   (st_reg.acceptWord),
        .inReady  (bufInReady),
        .outValid (bufOutValid),
        .outData  (bufOutData),
        .outReady (bufOutReady)
    );

    // next-state logic for the whole stage
    always_comb begin
        st_next = st_reg;

        // serial monitor: data and a one-cycle clock pulse in the cycle after each bit
        st_next.serClock = ENHANCED && rxBitStrobe;
        if (rxBitStrobe) begin
            st_next.serData = ENHANCED ? rxBitValue : 1'b0;
        end

        // word assembly, bit 1 ends in index 0
        if (rxFirstBit) begin
            st_next.bitCount = '0;
        end
        if (rxBitStrobe) begin
            st_next.shiftWord = fullWord;
            st_next.bitCount  = (rxFirstBit ? BIT_CNT_W'(0) : st_reg.bitCount) + 1'b1;
        end

        // offer an accepted word to the buffer and hold it until taken
        if (st_reg.acceptValid && bufInReady) begin
            st_next.acceptValid = 1'b0;
        end
        if (wordOk && accept && !st_reg.acceptValid) begin
            st_next.acceptValid = 1'b1;
            st_next.acceptWord  = checkedWord;
        end

        // a new word on the line drops the strobe
        if (rxFirstBit) begin
            st_next.strobe = 1'b0;
        end

        // output latch sequencing
        case (st_reg.state)
            ST_IDLE: begin
                if (bufOutValid) begin
                    st_next.latchWord = bufOutData;
                    st_next.refCount  = REF_LOAD;
                    st_next.strobe    = 1'b0;
                    st_next.state     = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (st_reg.refCount != '0) begin
                    st_next.refCount = st_reg.refCount - 1'b1;
                end else begin
                    st_next.trueOut   = st_reg.latchWord;
                    st_next.compOut   = ENHANCED ? ~st_reg.latchWord : WORD_ZERO;
                    st_next.outEnable = WORD_ONES;
                    st_next.strobe    = 1'b1;
                    st_next.state     = ST_IDLE;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase

        // master reset clears latch and receiver, outputs back to reset image
        if (masterClear) begin
            st_next = RESET_STATE;
        end
        if (!ce) begin
            st_next = st_reg;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign rxReady         = !st_reg.acceptValid;
    assign wordOut         = st_reg.trueOut;
    assign wordOutN        = st_reg.compOut;
    assign wordOutEn       = st_reg.outEnable;
    assign newWordStrobe   = st_reg.strobe;
    assign serialClockOut  = st_reg.serClock;
    assign serial_word_out = st_reg.serData;
endmodule // arinc_word_output_stage
`default_nettype wire

// ==== dv/arinc_word_output_stage_props.sv ====
// port-level assertion checker for the word output stage
`timescale 1ns/100ps
`default_nettype none
module arinc_word_output_stage_props
    import arinc_out_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 global_reset_n,
    input wire logic                 rxFirstBit,
    input wire logic                 rxBitStrobe,
    input wire logic                 rxBitValue,
    input wire logic                 rxReady,
    input wire logic [WORD_BITS-1:0] wordOut,
    input wire logic [WORD_BITS-1:0] wordOutN,
    input wire logic [WORD_BITS-1:0] wordOutEn,
    input wire logic                 newWordStrobe,
    input wire logic                 serialClockOut,
    input wire logic                 serial_word_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [7:0] lowCount_reg;
    // cycles the strobe has stayed low, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowCount_reg <= 8'h00;
        end else if (newWordStrobe) begin
            lowCount_reg <= 8'h00;
        end else if (lowCount_reg != 8'hFF) begin
            lowCount_reg <= lowCount_reg + 8'h01;
        end
    end
    // steps of a monitored bit and of a master clear
    sequence bitTaken;
        rxBitStrobe && global_reset_n;
    endsequence
    sequence bitShown;
        serialClockOut && (serial_word_out == $past(rxBitValue));
    endsequence
    sequence masterClear;
        !global_reset_n;
    endsequence
    sequence clearedImage;
        (wordOut == WORD_ZERO) && !newWordStrobe && rxReady && !serialClockOut;
    endsequence
    compl_match_a: assert property (wordOutN == ~wordOut)
        else $error("complement outputs differ from true outputs");
    always_driven_a: assert property (wordOutEn == WORD_ONES)
        else $error("word outputs released");
    word_hold_a: assert property ((!$rose(newWordStrobe) && $past(global_reset_n))
        |-> $stable(wordOut))
        else $error("word outputs changed without strobe rise");
    strobe_drop_a: assert property ((rxFirstBit && newWordStrobe && global_reset_n) |=> !newWordStrobe)
        else $error("strobe kept high after first bit");
    master_clear_a: assert property (masterClear |=> clearedImage)
        else $error("master reset image wrong");
    serial_pulse_a: assert property (bitTaken |=> bitShown)
        else $error("serial monitor missed a bit");
    serial_cause_a: assert property (serialClockOut |-> $past(rxBitStrobe))
        else $error("serial clock without received bit");
    strobe_gap_a: assert property ($rose(newWordStrobe) |-> (lowCount_reg >= 8'h7C))
        else $error("strobe rose before one reference period");
endmodule // arinc_word_output_stage_props
`default_nettype wire

// ==== dv/arinc_bus_model.sv ====
// receiver-side model feeding decoded bits and framing pulses
`timescale 1ns/100ps
`default_nettype none
module arinc_bus_model (
    input  wire logic clk,
    output logic      rxFirstBit,
    output logic      rxBitStrobe,
    output logic      rxBitValue,
    output logic      rxWordDone
);
    // quiet line at time zero
    initial begin
        rxFirstBit  = 1'h0;
        rxBitStrobe = 1'h0;
        rxBitValue  = 1'h0;
        rxWordDone  = 1'h0;
    end
    // one word, bit 1 first, a gap cycle after each bit
    task automatic sendWord(input logic [31:0] w, input int nBits);
        @(negedge clk);
        rxFirstBit = 1'h1;
        @(negedge clk);
        rxFirstBit = 1'h0;
        for (int i = 0; i < nBits; i++) begin
            rxBitStrobe = 1'h1;
            rxBitValue  = w[i];
            @(negedge clk);
            rxBitStrobe = 1'h0;
            rxBitValue  = ~w[i]; // stale bit is not held
            @(negedge clk);
        end
        rxWordDone = 1'h1;
        @(negedge clk);
        rxWordDone = 1'h0;
    endtask
endmodule // arinc_bus_model
`default_nettype wire

// ==== dv/tb_arinc_word_output_stage.sv ====
// self-checking bench for the word output stage
`timescale 1ns/100ps
`default_nettype none
bind arinc_word_output_stage arinc_word_output_stage_props chk_u (
    .clk(clk), .rst(rst), .global_reset_n(global_reset_n), .rxFirstBit(rxFirstBit),
    .rxBitStrobe(rxBitStrobe), .rxBitValue(rxBitValue), .rxReady(rxReady), .wordOut(wordOut),
    .wordOutN(wordOutN), .wordOutEn(wordOutEn), .newWordStrobe(newWordStrobe),
    .serialClockOut(serialClockOut), .serial_word_out(serial_word_out)
);
module tb_arinc_word_output_stage
    import arinc_out_pkg::*;
;
    typedef struct {
        logic [7:0] label; logic [1:0] sd; logic [21:0] data; logic par;
        logic [7:0] mask; logic [2:0] en; logic [1:0] sdv; logic acc;
    } row_s;
    // en is {sdEnable, thirdEnable, secondEnable}
    row_s rows [9] = '{
        '{8'h80, 2'h0, 22'h15_5555, 1'h0, 8'hFC, 3'h0, 2'h0, 1'h1},
        '{8'h83, 2'h0, 22'h3F_FFFF, 1'h1, 8'hFC, 3'h0, 2'h0, 1'h1},
        '{8'h84, 2'h0, 22'h00_1234, 1'h0, 8'hFC, 3'h0, 2'h0, 1'h0},
        '{8'hAA, 2'h0, 22'h0A_BCDE, 1'h1, 8'hFC, 3'h1, 2'h0, 1'h1},
        '{8'hBB, 2'h0, 22'h12_3457, 1'h1, 8'hFC, 3'h2, 2'h0, 1'h1},
        '{8'hAA, 2'h0, 22'h00_0001, 1'h0, 8'hFC, 3'h2, 2'h0, 1'h0},
        '{8'h81, 2'h2, 22'h2B_0F0F, 1'h0, 8'hFC, 3'h4, 2'h2, 1'h1},
        '{8'h81, 2'h1, 22'h2B_0F0F, 1'h0, 8'hFC, 3'h4, 2'h2, 1'h0},
        '{8'h37, 2'h3, 22'h00_0000, 1'h1, 8'h00, 3'h0, 2'h0, 1'h1}};
    logic clk, rst, ce, global_reset_n, parityEnable, rxFirstBit, rxBitStrobe, rxBitValue;
    logic rxWordDone, secondEnable, thirdEnable, sdEnable, rxReady, newWordStrobe;
    logic serialClockOut, serial_word_out;
    logic [7:0] label_match_primary, labelMask, label_match_second, label_match_third;
    logic [1:0] sdValue;
    logic [WORD_BITS-1:0] wordOut, wordOutN, wordOutEn, last, w1, w2;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    arinc_word_output_stage #(.ENHANCED(1'h1)) dut_u (
        .clk(clk), .rst(rst), .ce(ce), .global_reset_n(global_reset_n),
        .parityEnable(parityEnable), .rxFirstBit(rxFirstBit), .rxBitStrobe(rxBitStrobe),
        .rxBitValue(rxBitValue), .rxWordDone(rxWordDone), .label_match_primary(label_match_primary),
        .labelMask(labelMask), .label_match_second(label_match_second),
        .label_match_third(label_match_third), .secondEnable(secondEnable),
        .thirdEnable(thirdEnable), .sdEnable(sdEnable), .sdValue(sdValue), .rxReady(rxReady),
        .wordOut(wordOut), .wordOutN(wordOutN), .wordOutEn(wordOutEn),
        .newWordStrobe(newWordStrobe), .serialClockOut(serialClockOut),
        .serial_word_out(serial_word_out));
    arinc_bus_model bus_u (
        .clk(clk), .rxFirstBit(rxFirstBit), .rxBitStrobe(rxBitStrobe),
        .rxBitValue(rxBitValue), .rxWordDone(rxWordDone));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // label sent big-endian: word bit 1 is label bit 7
    function automatic logic [31:0] mkWord(input row_s r);
        logic [31:0] w;
        w = {r.data, r.sd, 8'h00};
        for (int i = 0; i < 8; i++) begin
            w[i] = r.label[7 - i];
        end
        return w;
    endfunction
    function automatic logic [31:0] expWord(input logic [31:0] w, input logic par);
        return par ? {~^w, w[30:0]} : w;
    endfunction
    task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic checkOut(input logic [31:0] e);
        chkWord("wordOut", e, wordOut);
        chkWord("wordOutN", ~e, wordOutN);
        chkWord("wordOutEn", WORD_ONES, wordOutEn);
    endtask
    task automatic waitStrobe(input logic lvl);
        int n;
        n = 0;
        while (newWordStrobe !== lvl && n < 600) begin
            @(negedge clk);
            n++;
        end
        chkBit("newWordStrobe", lvl, newWordStrobe);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        {clk, ce, rst, global_reset_n, parityEnable} = 5'h0F;
        {secondEnable, thirdEnable, sdEnable, sdValue} = 5'h00;
        label_match_primary = 8'h80;
        labelMask = 8'hFC;
        label_match_second = 8'hAA;
        label_match_third = 8'hBB;
        w1 = 32'hDEAD_BEEF;
        w2 = 32'h1234_5670;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        checkOut(WORD_ZERO);
        chkBit("rxReady", 1'h1, rxReady);
        last = WORD_ZERO;
        foreach (rows[k]) begin
            @(negedge clk);
            parityEnable = rows[k].par;
            labelMask = rows[k].mask;
            {sdEnable, thirdEnable, secondEnable} = rows[k].en;
            sdValue = rows[k].sdv;
            bus_u.sendWord(mkWord(rows[k]), 32);
            if (rows[k].acc) begin
                last = expWord(mkWord(rows[k]), rows[k].par);
                waitStrobe(1'h1);
            end else begin
                repeat (200) @(negedge clk);
            end
            chkBit("newWordStrobe", rows[k].acc, newWordStrobe);
            checkOut(last);
        end
        // short frame is dropped, outputs hold
        parityEnable = 1'h0;
        labelMask = 8'h00;
        bus_u.sendWord(w1, 31);
        repeat (200) @(negedge clk);
        chkBit("newWordStrobe", 1'h0, newWordStrobe);
        checkOut(last);
        // back-to-back words pass through the buffer in order
        bus_u.sendWord(w1, 32);
        bus_u.sendWord(w2, 32);
        waitStrobe(1'h1);
        checkOut(w1);
        waitStrobe(1'h0);
        waitStrobe(1'h1);
        checkOut(w2);
        // async reset in mid-run, then recovery
        rst = 1'h1;
        #1;
        checkOut(WORD_ZERO);
        @(negedge clk);
        rst = 1'h0;
        bus_u.sendWord(w2, 32);
        waitStrobe(1'h1);
        checkOut(w2);
        // master reset clears latch and strobe
        global_reset_n = 1'h0;
        @(negedge clk);
        global_reset_n = 1'h1;
        checkOut(WORD_ZERO);
        chkBit("newWordStrobe", 1'h0, newWordStrobe);
        print_verdict();
    end
endmodule // tb_arinc_word_output_stage
`default_nettype wire
